//--- include/cso_pkg.sv
package cso_pkg;
	localparam int PC_W = 13;
	localparam logic [7:0] ADDR_STATUS = 8'h03;
	localparam logic [7:0] ADDR_STATUS_HI = 8'h83;
	localparam logic [7:0] ADDR_OPTION = 8'h81;
	localparam logic [6:0] ADDR_LOW_MASK = 7'h7f;
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam logic [12:0] VEC_RESET = 13'h0000;
	localparam logic [12:0] VEC_IRQ = 13'h0004;
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_PD = 3;
	localparam int ST_TO = 4;
	localparam int ST_BANK_LO = 5;
	localparam int ST_BANK_HI = 6;
	localparam int ST_IND_BANK = 7;
	localparam int OP_RATE_LSB = 0;
	localparam int OP_PSA = 3;
	localparam int OP_TSE = 4;
	localparam int OP_TCS = 5;
	localparam int OP_EDGE = 6;
	localparam int OP_PULLUP = 7;
	localparam logic [3:0] DIV_NONE = 4'h0;

	typedef enum logic [2:0] {
		CSO_OP_PASS = 3'h0,
		CSO_OP_ADD = 3'h1,
		CSO_OP_SUB = 3'h3,
		CSO_OP_ROTL = 3'h2,
		CSO_OP_ROTR = 3'h6
	} cso_alu_op_t;

	typedef struct packed {
		cso_alu_op_t op;
		logic [7:0] a;
		logic [7:0] b;
	} cso_alu_req_t;

	typedef struct packed {
		logic upd_z;
		logic upd_dc;
		logic upd_c;
	} cso_flag_ctl_t;

	typedef struct packed {
		logic [7:0] result;
		logic z;
		logic dc;
		logic c;
	} cso_flag_res_t;
endpackage

//--- hw/cso_flag_calc.sv
`timescale 1ns/100ps
module cso_flag_calc
	import cso_pkg::*;
(
	input wire cso_alu_req_t i_req,
	input wire logic i_carry,
	output cso_flag_res_t o_res
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] addend;
	logic cin;

	always_comb
	begin
		// subtraction adds the two's complement, so carry reads as no-borrow
		addend = (i_req.op == CSO_OP_SUB) ? ~i_req.b : i_req.b;
		cin = (i_req.op == CSO_OP_SUB);
		sum = {1'b0, i_req.a} + {1'b0, addend} + {8'h00, cin};
		nib = {1'b0, i_req.a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
		o_res.dc = nib[4];
		o_res.c = sum[8];
		o_res.result = sum[7:0];
		case (i_req.op)
			CSO_OP_ADD, CSO_OP_SUB:
			begin
				o_res.result = sum[7:0];
			end
			CSO_OP_ROTL:
			begin
				o_res.result = {i_req.a[6:0], i_carry};
				o_res.c = i_req.a[7];
			end
			CSO_OP_ROTR:
			begin
				o_res.result = {i_carry, i_req.a[7:1]};
				o_res.c = i_req.a[0];
			end
			default:
			begin
				o_res.result = i_req.b;
			end
		endcase
		o_res.z = (o_res.result == 8'h00);
	end
endmodule

//--- hw/cso_core_regs.sv
`timescale 1ns/100ps
// How it works
// - thirteen-bit program counter, 8K word space
// - fetch address wraps into implemented memory
// - reset fetches zero, interrupt loads four
// - arithmetic flags override explicit status writes
// - timeout and powerdown flags ignore writes
// - clearing status zeroes top, sets zero
// - status mirrored at both bank addresses
// - bank bit five selects upper bank
// - subtraction carries act as inverted borrows
// - option bits read-write, reset to one
// - option bit seven disables port pull-ups
// - option bit six picks interrupt edge
// - rate field sets timer/watchdog division
// - assign bit routes prescaler watchdog or timer
module cso_core_regs
	import cso_pkg::*;
#(
	parameter int IMPL_BITS = 11
)
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_pc_inc,
	input wire logic i_pc_load,
	input wire logic [12:0] i_pc_target,
	input wire logic i_irq_take,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire cso_alu_req_t i_alu_req,
	input wire cso_flag_ctl_t i_flag_ctl,
	input wire logic i_watchdog_clear_op,
	input wire logic i_sleep_op,
	input wire logic i_watchdog_timeout,
	output logic [12:0] o_pc,
	output logic [12:0] o_fetch_addr,
	output logic [7:0] o_rd_data,
	output logic [7:0] o_alu_result,
	output logic [7:0] o_status,
	output logic [7:0] o_option,
	output logic o_bank_select_low,
	output logic o_pullup_disable,
	output logic o_ext_irq_edge_select,
	output logic o_timer_clock_source,
	output logic o_timer_pin_edge_select,
	output logic o_prescaler_assign,
	output logic [3:0] o_timer_div_log2,
	output logic [3:0] o_watchdog_div_log2
);
	localparam logic [12:0] IMPL_MASK = 13'((1 << IMPL_BITS) - 1);

	logic [12:0] pc;
	logic [12:0] next_pc;
	logic [7:0] status;
	logic [7:0] next_status;
	logic [7:0] option;
	logic [7:0] next_option;
	logic st_sel;
	logic op_sel;
	cso_flag_res_t calc;

	cso_flag_calc u_calc (
		.i_req(i_alu_req),
		.i_carry(status[ST_C]),
		.o_res(calc)
	);

	// bank bit 7 of the address is ignored so both banks hit one register
	assign st_sel = (i_addr[6:0] & ADDR_LOW_MASK) == ADDR_STATUS[6:0];
	assign op_sel = i_addr == ADDR_OPTION;

	always_comb
	begin
		next_pc = pc;
		if (i_irq_take)
			next_pc = VEC_IRQ;
		else if (i_pc_load)
			next_pc = i_pc_target;
		else if (i_pc_inc)
			next_pc = pc + 13'h0001;
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pc <= VEC_RESET;
			o_fetch_addr <= VEC_RESET;
		end
		else
		begin
			pc <= next_pc;
			o_fetch_addr <= next_pc & IMPL_MASK;
		end
	end

	always_comb
	begin
		next_status = status;
		if (i_wr_en && st_sel)
		begin
			// top bits are stored as written; keeping them zero is up to software
			next_status[7:5] = i_wr_data[7:5];
			// any flag-updating instruction blocks the write to all three flags
			if (!(i_flag_ctl.upd_z || i_flag_ctl.upd_dc || i_flag_ctl.upd_c))
				next_status[2:0] = i_wr_data[2:0];
		end
		// a flag that the instruction computes beats the explicit write
		if (i_flag_ctl.upd_z)
			next_status[ST_Z] = calc.z;
		if (i_flag_ctl.upd_dc)
			next_status[ST_DC] = calc.dc;
		if (i_flag_ctl.upd_c)
			next_status[ST_C] = calc.c;
		// no write path reaches bits 4:3
		if (i_watchdog_clear_op)
		begin
			next_status[ST_TO] = 1'b1;
			next_status[ST_PD] = 1'b1;
		end
		if (i_sleep_op)
		begin
			next_status[ST_TO] = 1'b1;
			next_status[ST_PD] = 1'b0;
		end
		if (i_watchdog_timeout)
			next_status[ST_TO] = 1'b0;
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			status <= STATUS_RST;
		else
			status <= next_status;
	end

	always_comb
	begin
		next_option = option;
		if (i_wr_en && op_sel)
			next_option = i_wr_data;
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			option <= OPTION_RST;
			o_timer_div_log2 <= DIV_NONE;
			o_watchdog_div_log2 <= DIV_NONE;
		end
		else
		begin
			option <= next_option;
			// one prescaler: the side without it runs undivided
			if (next_option[OP_PSA])
			begin
				o_timer_div_log2 <= DIV_NONE;
				o_watchdog_div_log2 <= {1'b0, next_option[OP_RATE_LSB +: 3]};
			end
			else
			begin
				o_timer_div_log2 <= {1'b0, next_option[OP_RATE_LSB +: 3]} + 4'h1;
				o_watchdog_div_log2 <= DIV_NONE;
			end
		end
	end

	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_rd_data <= RD_UNMAPPED;
			o_alu_result <= 8'h00;
		end
		else
		begin
			o_alu_result <= calc.result;
			if (i_rd_en)
			begin
				if (st_sel)
					o_rd_data <= status;
				else if (op_sel)
					o_rd_data <= option;
				else
					o_rd_data <= RD_UNMAPPED;
			end
		end
	end

	assign o_pc = pc;
	assign o_status = status;
	assign o_option = option;
	assign o_bank_select_low = status[ST_BANK_LO];
	assign o_pullup_disable = option[OP_PULLUP];
	assign o_ext_irq_edge_select = option[OP_EDGE];
	assign o_timer_clock_source = option[OP_TCS];
	assign o_timer_pin_edge_select = option[OP_TSE];
	assign o_prescaler_assign = option[OP_PSA];

	property p_irq_vector;
		@(posedge i_mclk) disable iff (i_reset)
		i_irq_take |=> (o_pc == VEC_IRQ) && (o_fetch_addr == (VEC_IRQ & IMPL_MASK));
	endproperty
	a_irq_vector: assert property (p_irq_vector) else $error("irq vector not loaded");

	property p_pc_step;
		@(posedge i_mclk) disable iff (i_reset)
		(i_pc_inc && !i_pc_load && !i_irq_take) |=> o_pc == $past(o_pc) + 13'h0001;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc did not step");

	property p_wrap;
		@(posedge i_mclk) disable iff (i_reset)
		##1 ((o_fetch_addr & ~IMPL_MASK) == 13'h0000) && (o_fetch_addr == (o_pc & IMPL_MASK));
	endproperty
	a_wrap: assert property (p_wrap) else $error("fetch address escaped memory");

	property p_flag_wins;
		@(posedge i_mclk) disable iff (i_reset)
		(i_wr_en && st_sel && i_flag_ctl.upd_z) |=> status[ST_Z] == $past(calc.z);
	endproperty
	a_flag_wins: assert property (p_flag_wins) else $error("zero flag took write");

	property p_flag_hold;
		@(posedge i_mclk) disable iff (i_reset)
		(i_wr_en && st_sel && i_flag_ctl.upd_z && !i_flag_ctl.upd_c) |=>
			status[ST_C] == $past(status[ST_C]);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("carry took write");

	property p_ro_flags;
		@(posedge i_mclk) disable iff (i_reset)
		(!i_watchdog_clear_op && !i_sleep_op && !i_watchdog_timeout) |=>
			$stable(status[4:3]);
	endproperty
	a_ro_flags: assert property (p_ro_flags) else $error("reset flags changed");

	property p_mirror;
		@(posedge i_mclk) disable iff (i_reset)
		(i_wr_en && i_addr == ADDR_STATUS_HI) |=> o_bank_select_low == $past(i_wr_data[5]);
	endproperty
	a_mirror: assert property (p_mirror) else $error("upper status alias missed");

	property p_sub_borrow;
		@(posedge i_mclk) disable iff (i_reset)
		(i_flag_ctl.upd_c && i_alu_req.op == CSO_OP_SUB) |=>
			status[ST_C] == ($past(i_alu_req.a) >= $past(i_alu_req.b));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow polarity wrong");

	property p_option_rw;
		@(posedge i_mclk) disable iff (i_reset)
		(i_wr_en && op_sel) |=> ##1 (i_rd_en && op_sel) |=> o_rd_data == $past(option);
	endproperty
	a_option_rw: assert property (p_option_rw) else $error("option readback wrong");

	property p_prescale;
		@(posedge i_mclk) disable iff (i_reset)
		##1 (option[OP_PSA] ? (o_timer_div_log2 == DIV_NONE) :
			(o_timer_div_log2 == {1'b0, option[2:0]} + 4'h1));
	endproperty
	a_prescale: assert property (p_prescale) else $error("prescale route wrong");

	property p_timeout;
		@(posedge i_mclk) disable iff (i_reset)
		i_watchdog_timeout |=> !status[ST_TO];
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");
endmodule

//--- verif/cso_core_model.sv
`timescale 1ns/100ps
module cso_core_model
	import cso_pkg::*;
(
	input wire logic i_mclk,
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [7:0] o_addr,
	output logic [7:0] o_wr_data,
	output cso_alu_req_t o_alu_req,
	output cso_flag_ctl_t o_flag_ctl
);
	initial
	begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wr_data = 8'h00;
		o_alu_req = '0;
		o_flag_ctl = '0;
	end

	// one instruction, then an idle cycle so no strobe is raised twice in a step
	task automatic issue(input logic wr, input logic [7:0] addr, input logic [7:0] data,
		input cso_alu_op_t op, input logic [7:0] a, input cso_flag_ctl_t upd);
		o_wr_en = wr;
		o_rd_en = ~wr;
		o_addr = addr;
		o_wr_data = (addr[6:0] == 7'h03) ? (data & 8'h3f) : data;
		o_alu_req = '{op, a, data};
		o_flag_ctl = upd;
		@(negedge i_mclk);
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_flag_ctl = '0;
		@(negedge i_mclk);
	endtask
endmodule

//--- verif/tb_cso_core_regs.sv
`timescale 1ns/100ps
module tb_cso_core_regs
	import cso_pkg::*;
;
	logic i_mclk, i_reset, pc_inc, pc_load, irq_take, wd_clear, sleep_op, wd_timeout;
	logic wr_en, rd_en, bank, pu, edg, tcs, tse, prescaler_assign;
	logic [12:0] pc_target, pc, fetch;
	logic [7:0] addr, wr_data, rd_data, status, option, optv, alu_res;
	logic [3:0] tdiv, wdiv;
	cso_alu_req_t alu_req;
	cso_flag_ctl_t flag_ctl;
	int fails, check_count;

	cso_core_model core_u (.i_mclk(i_mclk), .o_wr_en(wr_en), .o_rd_en(rd_en),
		.o_addr(addr), .o_wr_data(wr_data), .o_alu_req(alu_req), .o_flag_ctl(flag_ctl));

	// smallest memory variant so the wrap shows with few bits
	cso_core_regs #(.IMPL_BITS(9)) dut_u (.i_mclk(i_mclk), .i_reset(i_reset),
		.i_pc_inc(pc_inc), .i_pc_load(pc_load), .i_pc_target(pc_target),
		.i_irq_take(irq_take), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
		.i_wr_data(wr_data), .i_alu_req(alu_req), .i_flag_ctl(flag_ctl),
		.i_watchdog_clear_op(wd_clear), .i_sleep_op(sleep_op),
		.i_watchdog_timeout(wd_timeout), .o_pc(pc), .o_fetch_addr(fetch),
		.o_rd_data(rd_data), .o_alu_result(alu_res), .o_status(status), .o_option(option),
		.o_bank_select_low(bank), .o_pullup_disable(pu), .o_ext_irq_edge_select(edg),
		.o_timer_clock_source(tcs), .o_timer_pin_edge_select(tse),
		.o_prescaler_assign(prescaler_assign), .o_timer_div_log2(tdiv), .o_watchdog_div_log2(wdiv));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic pulse(input int k);
		wd_clear = (k == 0);
		sleep_op = (k == 1);
		wd_timeout = (k == 2);
		@(negedge i_mclk);
		wd_clear = 1'b0;
		sleep_op = 1'b0;
		wd_timeout = 1'b0;
		@(negedge i_mclk);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	initial
	begin
		repeat (5000) @(posedge i_mclk);
		fails++;
		stop_test();
	end

	initial
	begin
		i_reset = 1'b1;
		{pc_inc, pc_load, irq_take, wd_clear, sleep_op, wd_timeout} = '0;
		pc_target = 13'h0000;
		fails = 0;
		check_count = 0;
		repeat (5) @(negedge i_mclk);
		i_reset = 1'b0;
		@(negedge i_mclk);
		chk(status, 8'h18);
		chk(option, 8'hff);
		chk(pc, 13'h0000);
		chk(wdiv, 4'h7);
		$display("reset test done");
		core_u.issue(1'b1, 8'h83, 8'hff, CSO_OP_PASS, 8'h00, 3'b000);
		chk(status, 8'h3f);
		chk(bank, 1'b1);
		core_u.issue(1'b0, 8'h03, 8'h00, CSO_OP_PASS, 8'h00, 3'b000);
		chk(rd_data, 8'h3f);
		core_u.issue(1'b1, 8'h03, 8'h00, CSO_OP_PASS, 8'h00, 3'b100);
		chk(status, 8'h1f);
		core_u.issue(1'b1, 8'h03, 8'h01, CSO_OP_ADD, 8'h0f, 3'b111);
		chk(status, 8'h1a);
		core_u.issue(1'b1, 8'h03, 8'h00, CSO_OP_ROTL, 8'h80, 3'b001);
		chk(status, 8'h1b);
		core_u.issue(1'b1, 8'h03, 8'h00, CSO_OP_ROTR, 8'h02, 3'b001);
		chk(status, 8'h1a);
		core_u.issue(1'b1, 8'h03, 8'h01, CSO_OP_SUB, 8'h10, 3'b111);
		chk(status, 8'h19);
		chk(alu_res, 8'h0f);
		core_u.issue(1'b1, 8'h03, 8'h01, CSO_OP_ADD, 8'hff, 3'b111);
		chk(status, 8'h1f);
		chk(alu_res, 8'h00);
		$display("status test done");
		pulse(1);
		chk(status[4:3], 2'b10);
		pulse(2);
		chk(status[4:3], 2'b00);
		pulse(0);
		chk(status[4:3], 2'b11);
		$display("event test done");
		for (int r = 0; r < 16; r++)
		begin
			optv = {r[0], r[1], ~r[0], r[2], r[3], r[2], r[1], r[0]};
			core_u.issue(1'b1, 8'h81, optv, CSO_OP_PASS, 8'h00, 3'b000);
			chk(option, optv);
			chk({pu, edg, tcs, tse, prescaler_assign}, optv[7:3]);
			chk(tdiv, optv[3] ? 4'h0 : {1'b0, optv[2:0]} + 4'h1);
			chk(wdiv, optv[3] ? {1'b0, optv[2:0]} : 4'h0);
		end
		core_u.issue(1'b0, 8'h81, 8'h00, CSO_OP_PASS, 8'h00, 3'b000);
		chk(rd_data, optv);
		core_u.issue(1'b0, 8'h05, 8'h00, CSO_OP_PASS, 8'h00, 3'b000);
		chk(rd_data, 8'h00);
		$display("option test done");
		pc_target = 13'h1fff;
		pc_load = 1'b1;
		@(negedge i_mclk);
		pc_load = 1'b0;
		chk(pc, 13'h1fff);
		chk(fetch, 13'h01ff);
		pc_inc = 1'b1;
		@(negedge i_mclk);
		chk(pc, 13'h0000);
		irq_take = 1'b1;
		@(negedge i_mclk);
		irq_take = 1'b0;
		pc_inc = 1'b0;
		chk(pc, 13'h0004);
		chk(fetch, 13'h0004);
		i_reset = 1'b1;
		@(negedge i_mclk);
		i_reset = 1'b0;
		@(negedge i_mclk);
		chk(pc, 13'h0000);
		chk(status, 8'h18);
		$display("counter test done");
		stop_test();
	end
endmodule
